// >>> verilog/rx_ovh_pkg.sv
// Shared types and constants for the receive overhead extraction ports.
package rx_ovh_pkg;

   // ==========================================================================
   // Overhead byte identifiers
   // ==========================================================================
   typedef enum logic [1:0] {
      CH_ORDERWIRE,
      CH_SECTION,
      CH_LINE
   } ovh_channel_t;

   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int CH_COUNT = 3;
   // Bytes per frame on each channel: E1 F1 E2, D1..D3, D4..D12.
   localparam logic [3:0] OW_BYTES = 4'h3;
   localparam logic [3:0] SEC_BYTES = 4'h3;
   localparam logic [3:0] LINE_BYTES = 4'h9;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   // ==========================================================================
   // Word carried from the framer domain to the link domain
   // ==========================================================================
   typedef struct packed {
      ovh_channel_t channel;
      logic first;
      logic [BYTE_W-1:0] data;
   } ovh_word_t;

   localparam int WORD_W = $bits(ovh_word_t);

endpackage

// >>> verilog/ovh_mem.sv
// Small dual-clock memory with registered read data.
`timescale 1ns/1ps
module ovh_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_wclk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic i_rclk,
   input wire logic i_re,
   input wire logic [AW-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge i_wclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // Read side runs on the falling edge of the link clock.
   always_ff @(negedge i_rclk) begin
      if (i_re) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

// >>> verilog/ovh_fifo.sv
// Dual-clock FIFO with gray pointers; read side on the falling link edge.
`timescale 1ns/1ps
module ovh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_rclk,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);

   logic [AW:0] wbin;
   logic [AW:0] wgray;
   logic [AW:0] rbin;
   logic [AW:0] rgray;
   logic [AW:0] rg_w1;
   logic [AW:0] rg_w2;
   logic [AW:0] wg_r1;
   logic [AW:0] wg_r2;
   logic rvalid;
   logic rrst1;
   logic rrst;

   wire [AW:0] next_wbin = wbin + 1'b1;
   wire [AW:0] next_rbin = rbin + 1'b1;
   wire full = wgray == {~rg_w2[AW:AW-1], rg_w2[AW-2:0]};
   wire empty = rgray == wg_r2;
   wire push = i_valid && o_ready;
   wire pop_mem = !empty && (!rvalid || i_ready);

   assign o_ready = !full && i_ce;
   assign o_valid = rvalid;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wbin <= '0;
         wgray <= '0;
         rg_w1 <= '0;
         rg_w2 <= '0;
      end else if (i_ce) begin
         rg_w1 <= rgray;
         rg_w2 <= rg_w1;
         if (push) begin
            wbin <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
         end
      end
   end

   always_ff @(negedge i_rclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rrst1 <= 1'b1;
         rrst <= 1'b1;
      end else begin
         rrst1 <= 1'b0;
         rrst <= rrst1;
      end
   end

   always_ff @(negedge i_rclk or posedge rrst) begin
      if (rrst) begin
         rbin <= '0;
         rgray <= '0;
         wg_r1 <= '0;
         wg_r2 <= '0;
         rvalid <= 1'b0;
      end else begin
         wg_r1 <= wgray;
         wg_r2 <= wg_r1;
         if (pop_mem) begin
            rbin <= next_rbin;
            rgray <= next_rbin ^ (next_rbin >> 1);
            rvalid <= 1'b1;
         end else if (i_ready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ovh_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
      .i_wclk(i_clk),
      .i_we(push),
      .i_waddr(wbin[AW-1:0]),
      .i_wdata(i_data),
      .i_rclk(i_rclk),
      .i_re(pop_mem),
      .i_raddr(rbin[AW-1:0]),
      .o_rdata(o_data)
   );
endmodule

// >>> verilog/rx_ovh_extract.sv
// Receive order-wire, section and line channel serial extraction ports.
`timescale 1ns/1ps
module rx_ovh_extract
   import rx_ovh_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_ovh_valid,
   output logic o_ovh_ready,
   input wire logic [1:0] i_ovh_channel,
   input wire logic i_ovh_first,
   input wire logic [BYTE_W-1:0] i_ovh_data,
   input wire logic i_rx_overhead_clock,
   output logic o_rx_orderwire_serial_data,
   output logic o_rx_orderwire_frame_strobe,
   output logic o_rx_orderwire_valid,
   output logic o_rx_section_channel_data,
   output logic o_rx_section_channel_valid,
   output logic o_rx_line_channel_data,
   output logic o_rx_line_channel_valid
);

   // ==========================================================================
   // Framer side: bytes tagged by channel enter the crossing FIFO
   // ==========================================================================
   ovh_word_t in_word;
   ovh_word_t out_word;
   logic out_valid;
   logic out_ready;

   assign in_word = ovh_word_t'({i_ovh_channel, i_ovh_first, i_ovh_data});

   ovh_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_valid(i_ovh_valid),
      .o_ready(o_ovh_ready),
      .i_data(in_word),
      .i_rclk(i_rx_overhead_clock),
      .o_valid(out_valid),
      .i_ready(out_ready),
      .o_data(out_word)
   );

   // ==========================================================================
   // Link side: serialiser on the falling edge of the overhead clock
   // ==========================================================================
   logic lrst1;
   logic lrst;
   logic busy;
   logic [2:0] bit_cnt;
   logic [BYTE_W-1:0] shift;
   ovh_channel_t cur_ch;
   logic cur_first;

   wire load = out_valid && (!busy || bit_cnt == BIT_LAST);
   wire shifting = busy && bit_cnt != BIT_LAST;
   assign out_ready = !busy || bit_cnt == BIT_LAST;

   always_ff @(negedge i_rx_overhead_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lrst1 <= 1'b1;
         lrst <= 1'b1;
      end else begin
         lrst1 <= 1'b0;
         lrst <= lrst1;
      end
   end

   always_ff @(negedge i_rx_overhead_clock or posedge lrst) begin
      if (lrst) begin
         busy <= 1'b0;
         bit_cnt <= '0;
         shift <= '0;
         cur_ch <= CH_ORDERWIRE;
         cur_first <= 1'b0;
      end else if (load) begin
         busy <= 1'b1;
         bit_cnt <= '0;
         shift <= out_word.data;
         cur_ch <= out_word.channel;
         cur_first <= out_word.first;
      end else if (shifting) begin
         bit_cnt <= bit_cnt + 3'h1;
         shift <= {shift[BYTE_W-2:0], 1'b0};
         cur_first <= 1'b0;
      end else begin
         busy <= 1'b0;
         cur_first <= 1'b0;
      end
   end

   // Output registers, MSB first, all launched on the falling edge.
   wire sel_ow = busy && cur_ch == CH_ORDERWIRE;
   wire sel_sec = busy && cur_ch == CH_SECTION;
   wire sel_line = busy && cur_ch == CH_LINE;

   always_ff @(negedge i_rx_overhead_clock or posedge lrst) begin
      if (lrst) begin
         o_rx_orderwire_serial_data <= 1'b0;
         o_rx_orderwire_frame_strobe <= 1'b0;
         o_rx_orderwire_valid <= 1'b0;
         o_rx_section_channel_data <= 1'b0;
         o_rx_section_channel_valid <= 1'b0;
         o_rx_line_channel_data <= 1'b0;
         o_rx_line_channel_valid <= 1'b0;
      end else begin
         o_rx_orderwire_serial_data <= sel_ow ? shift[BYTE_W-1] : 1'b0;
         o_rx_orderwire_valid <= sel_ow;
         o_rx_orderwire_frame_strobe <= sel_ow && cur_first;
         o_rx_section_channel_data <= sel_sec ? shift[BYTE_W-1] : 1'b0;
         o_rx_section_channel_valid <= sel_sec;
         o_rx_line_channel_data <= sel_line ? shift[BYTE_W-1] : 1'b0;
         o_rx_line_channel_valid <= sel_line;
      end
   end
endmodule

// >>> verification/rx_ovh_extract_sva.sv
// Assertions on the receive overhead extraction ports.
`timescale 1ns/1ps
module rx_ovh_extract_sva (
   input wire logic i_sys_rst,
   input wire logic i_rx_overhead_clock,
   input wire logic o_rx_orderwire_serial_data,
   input wire logic o_rx_orderwire_frame_strobe,
   input wire logic o_rx_orderwire_valid,
   input wire logic o_rx_section_channel_data,
   input wire logic o_rx_section_channel_valid,
   input wire logic o_rx_line_channel_data,
   input wire logic o_rx_line_channel_valid
);
   // ==========
   // Link side checks
   logic ow, st;
   logic [6:0] outs, rise;
   assign ow = o_rx_orderwire_valid;
   assign st = o_rx_orderwire_frame_strobe;
   assign outs = {o_rx_orderwire_serial_data, st, ow, o_rx_section_channel_data,
      o_rx_section_channel_valid, o_rx_line_channel_data, o_rx_line_channel_valid};
   // The value seen at each rise must still stand at the next fall.
   always_ff @(posedge i_rx_overhead_clock) rise <= outs;
   default clocking @(posedge i_rx_overhead_clock); endclocking
   default disable iff (i_sys_rst);
   property p_fall_only; @(negedge i_rx_overhead_clock) outs == rise; endproperty
   a_fall_only: assert property (p_fall_only) else $error("output moved on rise");
   property p_rst_zero; disable iff (1'b0) i_sys_rst |-> outs == 7'h0; endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("output set in reset");
   property p_strobe; st |-> ow [*8]; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe without byte");
   property p_strobe_once; st |=> !st [*7]; endproperty
   a_strobe_once: assert property (p_strobe_once) else $error("strobe too long");
   property p_ow; $rose(ow) |-> ow [*8]; endproperty
   a_ow: assert property (p_ow) else $error("orderwire byte cut");
   property p_sec; $rose(o_rx_section_channel_valid) |-> o_rx_section_channel_valid [*8];
   endproperty
   a_sec: assert property (p_sec) else $error("section byte cut");
   property p_line; $rose(o_rx_line_channel_valid) |-> o_rx_line_channel_valid [*8];
   endproperty
   a_line: assert property (p_line) else $error("line byte cut");
   property p_one; $onehot0({ow, o_rx_section_channel_valid, o_rx_line_channel_valid});
   endproperty
   a_one: assert property (p_one) else $error("two ports valid");
   c_frame: cover property (st);
   c_sec: cover property ($rose(o_rx_section_channel_valid));
   c_line: cover property ($rose(o_rx_line_channel_valid));
endmodule
bind rx_ovh_extract rx_ovh_extract_sva rx_ovh_extract_sva_i (.*);

// >>> verification/ovh_user_model.sv
// User logic that captures bytes from the three serial ports.
`timescale 1ns/1ps
module ovh_user_model (
   input wire logic i_clk,
   input wire logic [2:0] i_valid,
   input wire logic [2:0] i_data,
   input wire logic i_strobe
);
   // ==========
   // Capture on the rising edge
   logic [7:0] sh [3];
   int n [3] = '{0, 0, 0};
   int frames = 0;
   logic [7:0] got [3][$];
   always @(posedge i_clk) begin
      for (int c = 0; c < 3; c++) begin
         if (i_valid[c]) begin
            if (c == 0 && i_strobe) begin
               n[0] = 0;
               frames++;
            end
            sh[c] = {sh[c][6:0], i_data[c]};
            n[c]++;
            if (n[c] == 8) begin
               got[c].push_back(sh[c]);
               n[c] = 0;
            end
         end
      end
   end
endmodule

// >>> verification/tb.sv
// Self-checking testbench for the receive overhead extraction ports.
`timescale 1ns/1ps
module tb;
   // ==========
   // Design and user model
   logic i_clk = 0, lclk = 0, run = 1, i_sys_rst = 0, vld = 0, first = 0, ce = 1;
   logic [1:0] ch = 2'h0;
   logic [7:0] dat = 8'h0;
   logic rdy, st;
   logic [2:0] v, d;
   int n_mismatch = 0, tests_run = 0;
   rx_ovh_extract rx_ovh_extract_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
      .i_ovh_valid(vld), .o_ovh_ready(rdy), .i_ovh_channel(ch), .i_ovh_first(first),
      .i_ovh_data(dat), .i_rx_overhead_clock(lclk),
      .o_rx_orderwire_serial_data(d[0]), .o_rx_orderwire_frame_strobe(st),
      .o_rx_orderwire_valid(v[0]), .o_rx_section_channel_data(d[1]),
      .o_rx_section_channel_valid(v[1]), .o_rx_line_channel_data(d[2]),
      .o_rx_line_channel_valid(v[2]));
   ovh_user_model user_i (.i_clk(lclk), .i_valid(v), .i_data(d), .i_strobe(st));
   initial forever #50 i_clk = ~i_clk;
   initial begin
      #7;
      forever #32 if (run) lclk = ~lclk;
   end
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Holds the byte on offer until the edge that takes it; valid stays up.
   task automatic push(logic [1:0] c, logic f, logic [7:0] b);
      int i;
      ch = c;
      first = f;
      dat = b;
      vld = 1;
      for (i = 0; i < 300; i++) begin
         @(posedge i_clk);
         if (rdy === 1'b1) break;
      end
      #1;
      if (i == 300) begin
         n_mismatch++;
         results;
      end
   endtask
   task automatic wait_got(int c, int k);
      for (int i = 0; i < 3000 && user_i.got[c].size() < k; i++) @(posedge i_clk);
      #1;
      if (user_i.got[c].size() < k) begin
         n_mismatch++;
         results;
      end
   endtask
   // ==========
   // Scenarios
   task automatic t_frame;
      logic [7:0] b [15];
      for (int i = 0; i < 15; i++) b[i] = 8'(i * 49 + 90);
      for (int i = 0; i < 15; i++) push(i < 3 ? 2'h0 : i < 6 ? 2'h1 : 2'h2, i == 0, b[i]);
      vld = 0;
      wait_got(0, 3);
      wait_got(1, 3);
      wait_got(2, 9);
      for (int i = 0; i < 3; i++) chk("orderwire", user_i.got[0][i], b[i]);
      for (int i = 0; i < 3; i++) chk("section", user_i.got[1][i], b[i+3]);
      for (int i = 0; i < 9; i++) chk("line", user_i.got[2][i], b[i+6]);
      chk("frames", 8'(user_i.frames), 8'h1);
   endtask
   // Link clock held still so the buffer fills and refuses.
   task automatic t_full;
      run = 0;
      for (int i = 0; i < 32; i++) push(2'h2, 1'b0, 8'(i));
      chk("ready", {7'h0, rdy}, 8'h0);
      vld = 0;
      run = 1;
      wait_got(2, 41);
      for (int i = 0; i < 32; i++) chk("drain", user_i.got[2][9+i], 8'(i));
   endtask
   // Enable low refuses the framer side; channel code 3 reaches no port.
   task automatic t_hold;
      int k;
      int m;
      k = user_i.got[0].size() + user_i.got[1].size() + user_i.got[2].size();
      ce = 0;
      ch = 2'h1;
      first = 0;
      dat = 8'h5a;
      vld = 1;
      repeat (4) @(posedge i_clk);
      #1;
      chk("ready_held", {7'h0, rdy}, 8'h0);
      ce = 1;
      push(2'h3, 1'b0, 8'hff);
      vld = 0;
      repeat (40) @(posedge i_clk);
      #1;
      m = user_i.got[0].size() + user_i.got[1].size() + user_i.got[2].size();
      chk("bytes_none", 8'(m - k), 8'h0);
      chk("bits_none", 8'(user_i.n[0] + user_i.n[1] + user_i.n[2]), 8'h0);
      push(2'h1, 1'b0, 8'h5a);
      vld = 0;
      wait_got(1, 4);
      chk("section_after", user_i.got[1][3], 8'h5a);
   endtask
   // Reset rises after time zero so that the asynchronous reset sees an edge.
   initial begin
      #1 i_sys_rst = 1;
      repeat (10) @(posedge i_clk);
      #1 i_sys_rst = 0;
      t_frame;
      t_full;
      t_hold;
      results;
   end
endmodule
